// File: mcoag_pkg.sv
// Purpose: shared types and constants for the mac operand address and multiplier front end
// Assumes: 16-bit words, byte addresses, even word pointers
// Notes:   index pointers and offsets are loaded by the core; other controls arrive with each instruction or on fractional_shift_bit
package mcoag_pkg;

  localparam int unsigned WORD_W     = 16;
  localparam int unsigned PROD_W     = 32;
  localparam int unsigned EXT_W      = 40;
  localparam int unsigned GPR_NUM    = 16;
  localparam int unsigned GPR_IDX_W  = 4;

  localparam logic [15:0] PTR_STEP      = 16'h0002;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [15:0] DPRAM_BASE    = 16'hfa00;
  localparam logic [15:0] DPRAM_LAST    = 16'hfdff;
  localparam int unsigned EXEC_CYCLES   = 2;
  localparam logic [1:0]  EXEC_CNT_LAST = 2'(EXEC_CYCLES - 1);

  // pointer post-modification modes
  typedef enum logic [2:0] {
    MCOAG_PM_NONE = 3'b000,
    MCOAG_PM_INC  = 3'b001,
    MCOAG_PM_DEC  = 3'b010,
    MCOAG_PM_ADDQ = 3'b011,
    MCOAG_PM_SUBQ = 3'b100
  } mcoag_pmod_t;

  typedef enum logic [1:0] {
    MCOAG_OP_MAC  = 2'b00,
    MCOAG_OP_MACM = 2'b01,
    MCOAG_OP_MOV  = 2'b10,
    MCOAG_OP_STORE = 2'b11
  } mcoag_op_t;

  // one coprocessor instruction as handed over by the cpu core
  typedef struct packed {
    mcoag_op_t             op;
    logic                  dbl_indirect;
    logic [GPR_IDX_W-1:0]  gpr_sel;
    mcoag_pmod_t           gpr_mod;
    logic                  gpr_q_sel;
    logic                  idx_sel;
    mcoag_pmod_t           idx_mod;
    logic                  idx_q_sel;
    logic                  a_signed;
    logic                  b_signed;
  } mcoag_instr_t;

  // pointer and offset file seen by the address unit
  typedef struct packed {
    logic [15:0] index_pointer_a;
    logic [15:0] index_pointer_b;
    logic [15:0] index_offset_a;
    logic [15:0] index_offset_b;
    logic [15:0] gpr_offset_a;
    logic [15:0] gpr_offset_b;
  } mcoag_ptrs_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } mcoag_wr_t;

  function automatic logic [15:0] mcoag_post_mod(input logic [15:0] p,
                                                 input mcoag_pmod_t m,
                                                 input logic [15:0] q);
    case (m)
      MCOAG_PM_INC:  mcoag_post_mod = p + PTR_STEP;
      MCOAG_PM_DEC:  mcoag_post_mod = p - PTR_STEP;
      MCOAG_PM_ADDQ: mcoag_post_mod = p + q;
      MCOAG_PM_SUBQ: mcoag_post_mod = p - q;
      default:       mcoag_post_mod = p;
    endcase
  endfunction

  // inverse operation applied to the already modified pointer
  function automatic logic [15:0] mcoag_inverse_mod(input logic [15:0] p,
                                                    input mcoag_pmod_t m,
                                                    input logic [15:0] q);
    case (m)
      MCOAG_PM_INC:  mcoag_inverse_mod = p - PTR_STEP;
      MCOAG_PM_DEC:  mcoag_inverse_mod = p + PTR_STEP;
      MCOAG_PM_ADDQ: mcoag_inverse_mod = p - q;
      MCOAG_PM_SUBQ: mcoag_inverse_mod = p + q;
      default:       mcoag_inverse_mod = p;
    endcase
  endfunction

  function automatic logic in_dpram(input logic [15:0] a);
    in_dpram = (a >= DPRAM_BASE) && (a <= DPRAM_LAST);
  endfunction

endpackage

// File: mcoag_mult.sv
// Purpose: 16x16 signed/unsigned multiplier with one-bit fractional scaler
// Assumes: operands registered by the caller
// Notes:   one register stage; result is sign-extended to the accumulator width
`timescale 1ns/100ps
`default_nettype none
module mcoag_mult
  import mcoag_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic [WORD_W-1:0]     op_a,
  input  wire logic [WORD_W-1:0]     op_b,
  input  wire logic                  a_signed,
  input  wire logic                  b_signed,
  input  wire logic                  fractional_shift_bit,
  output logic      [EXT_W-1:0]      product_r
);
  logic signed [16:0] a_ext;
  logic signed [16:0] b_ext;
  logic signed [33:0] full;
  logic        [EXT_W-1:0] ext;

  always_comb begin
    a_ext = {a_signed & op_a[15], op_a};
    b_ext = {b_signed & op_b[15], op_b};
    full  = a_ext * b_ext;
    // sign extension keeps the unsigned*unsigned case positive via the 34-bit product
    ext   = {{(EXT_W-33){full[32]}}, full[32:0]};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      product_r <= '0;
    end else if (fractional_shift_bit) begin
      product_r <= {ext[EXT_W-2:0], 1'b0}; // [RQ18]
    end else begin
      product_r <= ext; // [RQ16]
    end
  end
endmodule
`default_nettype wire

// File: mcoag_top.sv
// Purpose: operand address generation, parallel move addressing, pipeline timing, multiplier
// Assumes: cpu core supplies gpr values, memory read data and accepts write requests
// Notes:   four stages fetch/decode/execute/writeback, two-cycle execute
// What this block does
// [RQ1] two pointers: any gpr plus index pointer
// [RQ2] separate offset pairs for gpr and index
// [RQ3] gpr pointer addresses whole memory space
// [RQ4] index addresses limited to dual-port ram; the range flag exempts mov
// [RQ5] five post-modify modes, sixteen gpr pointers
// [RQ6] parallel move only for mac-with-move, double-indirect
// [RQ7] index operand copied during arithmetic
// [RQ8] write-back address inverts index post-modification
// [RQ9] all four stages; fetch takes double word
// [RQ10] decode computes addresses, fetches, post-modifies
// [RQ11] execute computes; gpr pointer written back there
// [RQ12] write-back stage stores moved operand
// [RQ13] software spaces coprocessor register reads
// [RQ14] store instruction reads registers without gap
// [RQ15] every operation takes two execute cycles
// [RQ16] 16x16 product, signed/unsigned, int/fraction
// [RQ17] multiplier fed from both operand buses
// [RQ18] scaler shifts product left when fractional
// [RQ19] fractional operands are 1.15 format
// [RQ20] write-back uses post-modified pointer, same offset
`timescale 1ns/100ps
`default_nettype none
module mcoag_top
  import mcoag_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      fetch_word_valid,
  input  wire logic [WORD_W-1:0]         fetch_word,
  input  wire mcoag_pkg::mcoag_instr_t   instr_in,
  input  wire logic [WORD_W-1:0]         gpr_value,
  input  wire logic [WORD_W-1:0]         operand_bus_a,
  input  wire logic [WORD_W-1:0]         operand_bus_b,
  input  wire logic                      fractional_shift_bit,
  input  wire logic                      ptr_load,
  input  wire mcoag_pkg::mcoag_ptrs_t    ptr_load_val,
  output logic                           instr_ready_r,
  output logic [GPR_IDX_W-1:0]           gpr_rd_sel_r,
  output logic [WORD_W-1:0]              addr_a_r,
  output logic [WORD_W-1:0]              addr_b_r,
  output logic                           addr_valid_r,
  output logic                           idx_range_err_r,
  output logic                           gpr_wr_en_r,
  output logic [GPR_IDX_W-1:0]           gpr_wr_sel_r,
  output logic [WORD_W-1:0]              gpr_wr_val_r,
  output mcoag_pkg::mcoag_wr_t           move_wr_r,
  output logic [EXT_W-1:0]               product_r,
  output logic                           exec_done_r,
  output logic                           store_ok_r,
  output mcoag_pkg::mcoag_ptrs_t         ptrs_r
);
  import mcoag_pkg::*;

  typedef enum logic [1:0] {
    MCOAG_F_IDLE  = 2'b00,
    MCOAG_F_WORD1 = 2'b01,
    MCOAG_F_WORD2 = 2'b10
  } mcoag_fetch_t;

  mcoag_fetch_t  fetch_r;
  mcoag_fetch_t  fetch_nxt;
  mcoag_instr_t  dec_instr_r;
  logic          dec_valid_r;
  mcoag_instr_t  ex_instr_r;
  logic          ex_valid_r;
  logic [1:0]    ex_cnt_r;
  logic [15:0]   ex_gpr_new_r;
  logic [15:0]   ex_idx_new_r;
  logic [15:0]   ex_move_data_r;
  logic          ex_move_r;
  logic [15:0]   ex_idx_q_r;
  logic [WORD_W-1:0] mul_a_r;
  logic [WORD_W-1:0] mul_b_r;
  logic          ex_signa_r;
  logic          ex_signb_r;
  logic          ex_stall;
  logic          dec_take;
  logic          ex_last;

  logic [15:0]   idx_ptr;
  logic [15:0]   idx_q;
  logic [15:0]   gpr_q;
  logic [15:0]   gpr_new;
  logic [15:0]   idx_new;
  logic          move_en;
  logic          long_reach;

  assign ex_last  = ex_valid_r && (ex_cnt_r == EXEC_CNT_LAST);
  assign ex_stall = ex_valid_r && !ex_last;
  assign dec_take = dec_valid_r && !ex_stall;

  // fetch: every coprocessor instruction is taken as two words
  always_comb begin
    fetch_nxt = fetch_r;
    case (fetch_r)
      MCOAG_F_IDLE:  fetch_nxt = MCOAG_F_WORD1;
      MCOAG_F_WORD1: if (fetch_word_valid && !ex_stall) fetch_nxt = MCOAG_F_WORD2; // [RQ9]
      MCOAG_F_WORD2: if (fetch_word_valid) fetch_nxt = MCOAG_F_WORD1; // [RQ9]
      default:       fetch_nxt = MCOAG_F_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fetch_r       <= MCOAG_F_IDLE;
      instr_ready_r <= 1'b0;
    end else begin
      fetch_r       <= fetch_nxt;
      instr_ready_r <= (fetch_nxt == MCOAG_F_WORD1);
    end
  end

  // second word completes the instruction and moves it into decode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dec_valid_r <= 1'b0;
      dec_instr_r <= '0;
    end else if (fetch_r == MCOAG_F_WORD2 && fetch_word_valid) begin
      dec_valid_r <= 1'b1; // [RQ9]
      dec_instr_r <= instr_in;
    end else if (dec_take) begin
      dec_valid_r <= 1'b0;
    end
  end

  // decode: address calculation and post-modification
  always_comb begin
    idx_ptr = dec_instr_r.idx_sel ? ptrs_r.index_pointer_b : ptrs_r.index_pointer_a; // [RQ1]
    idx_q   = dec_instr_r.idx_q_sel ? ptrs_r.index_offset_b : ptrs_r.index_offset_a; // [RQ2]
    gpr_q   = dec_instr_r.gpr_q_sel ? ptrs_r.gpr_offset_b : ptrs_r.gpr_offset_a; // [RQ2]
    gpr_new = mcoag_post_mod(gpr_value, dec_instr_r.gpr_mod, gpr_q); // [RQ5]
    idx_new = mcoag_post_mod(idx_ptr, dec_instr_r.idx_mod, idx_q); // [RQ5]
    move_en = (dec_instr_r.op == MCOAG_OP_MACM) && dec_instr_r.dbl_indirect; // [RQ6]
    long_reach = (dec_instr_r.op == MCOAG_OP_MOV); // [RQ4]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gpr_rd_sel_r <= '0;
    end else begin
      gpr_rd_sel_r <= instr_in.gpr_sel; // [RQ5]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_a_r        <= RESET_WORD;
      addr_b_r        <= RESET_WORD;
      addr_valid_r    <= 1'b0;
      idx_range_err_r <= 1'b0;
    end else begin
      addr_valid_r    <= dec_take && dec_instr_r.dbl_indirect; // [RQ10]
      idx_range_err_r <= 1'b0;
      if (dec_take && dec_instr_r.dbl_indirect) begin
        addr_a_r <= gpr_value; // [RQ3]
        addr_b_r <= idx_ptr; // [RQ10]
        // out-of-ram index access is flagged except for mov, the core suppresses it
        idx_range_err_r <= !long_reach && !in_dpram(idx_ptr); // [RQ4]
      end
    end
  end

  // execute stage registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ex_valid_r     <= 1'b0;
      ex_instr_r     <= '0;
      ex_cnt_r       <= '0;
      ex_gpr_new_r   <= RESET_WORD;
      ex_idx_new_r   <= RESET_WORD;
      ex_move_r      <= 1'b0;
      ex_idx_q_r     <= RESET_WORD;
    end else if (dec_take) begin
      ex_valid_r     <= 1'b1;
      ex_instr_r     <= dec_instr_r;
      ex_cnt_r       <= '0;
      ex_gpr_new_r   <= gpr_new;
      ex_idx_new_r   <= idx_new;
      ex_move_r      <= move_en; // [RQ6]
      ex_idx_q_r     <= idx_q; // [RQ20]
    end else if (ex_stall) begin
      ex_cnt_r       <= ex_cnt_r + 2'h1; // [RQ15]
    end else begin
      ex_valid_r     <= 1'b0;
    end
  end

  // operand buses sampled as the instruction enters execute
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mul_a_r        <= '0;
      mul_b_r        <= '0;
      ex_signa_r     <= 1'b0;
      ex_signb_r     <= 1'b0;
      ex_move_data_r <= RESET_WORD;
    end else if (dec_take) begin
      mul_a_r        <= operand_bus_a; // [RQ17]
      mul_b_r        <= operand_bus_b; // [RQ17]
      ex_signa_r     <= dec_instr_r.a_signed;
      ex_signb_r     <= dec_instr_r.b_signed;
      ex_move_data_r <= operand_bus_b; // [RQ7]
    end
  end

  // fractional form (1.15) is the signed product shifted by the scaler
  mcoag_mult u_mult (
    .core_clk             (core_clk),
    .rst                  (rst),
    .op_a                 (mul_a_r),
    .op_b                 (mul_b_r),
    .a_signed             (ex_signa_r),
    .b_signed             (ex_signb_r),
    .fractional_shift_bit (fractional_shift_bit), // [RQ19]
    .product_r            (product_r)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      exec_done_r <= 1'b0;
      store_ok_r  <= 1'b0;
    end else begin
      exec_done_r <= ex_last; // [RQ15]
      // store may read coprocessor registers the cycle after completion
      store_ok_r  <= ex_last || !ex_valid_r; // [RQ14]
    end
  end

  // gpr pointer written back inside execute
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gpr_wr_en_r  <= 1'b0;
      gpr_wr_sel_r <= '0;
      gpr_wr_val_r <= RESET_WORD;
    end else begin
      gpr_wr_en_r  <= ex_valid_r && (ex_cnt_r == 2'h0) &&
                      ex_instr_r.dbl_indirect && (ex_instr_r.gpr_mod != MCOAG_PM_NONE); // [RQ11]
      gpr_wr_sel_r <= ex_instr_r.gpr_sel;
      gpr_wr_val_r <= ex_gpr_new_r;
    end
  end

  // index pointers and offsets; core load wins over post-modification
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptrs_r <= '0;
    end else if (ptr_load) begin
      ptrs_r <= ptr_load_val;
    end else if (dec_take && dec_instr_r.dbl_indirect) begin
      if (dec_instr_r.idx_sel) begin
        ptrs_r.index_pointer_b <= idx_new; // [RQ10]
      end else begin
        ptrs_r.index_pointer_a <= idx_new; // [RQ10]
      end
    end
  end

  // write-back stage: moved operand goes to the inverse-modified address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      move_wr_r <= '0;
    end else begin
      move_wr_r.valid <= ex_last && ex_move_r; // [RQ12]
      move_wr_r.addr  <= mcoag_inverse_mod(ex_idx_new_r, ex_instr_r.idx_mod, ex_idx_q_r); // [RQ8] [RQ20]
      move_wr_r.data  <= ex_move_data_r; // [RQ7]
    end
  end

endmodule
`default_nettype wire

// File: mcoag_top_monitor.sv
// Purpose: port-level timing checks for mcoag_top
// Assumes: single clock, synchronous active-high reset
// Notes:   attached to every mcoag_top by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module mcoag_top_monitor
  import mcoag_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic                 fetch_word_valid,
  input wire logic [15:0]          operand_bus_b,
  input wire logic                 fractional_shift_bit,
  input wire logic                 addr_valid_r,
  input wire logic [15:0]          addr_b_r,
  input wire logic                 idx_range_err_r,
  input wire logic                 gpr_wr_en_r,
  input wire mcoag_pkg::mcoag_wr_t move_wr_r,
  input wire logic [39:0]          product_r,
  input wire logic                 exec_done_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_exec;
    addr_valid_r |-> ##2 exec_done_r;
  endproperty
  a_exec: assert property (p_exec) else $error("done late");
  property p_cause;
    exec_done_r |-> $past(addr_valid_r, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("done without decode");
  // word1 and word2 sit on the two edges just before the decode take
  property p_words;
    addr_valid_r |-> $past(fetch_word_valid, 2) && $past(fetch_word_valid, 3);
  endproperty
  a_words: assert property (p_words) else $error("single word fetch");
  property p_gwb;
    gpr_wr_en_r |-> ##1 exec_done_r;
  endproperty
  a_gwb: assert property (p_gwb) else $error("gpr write outside execute");
  property p_mvdone;
    move_wr_r.valid |-> exec_done_r;
  endproperty
  a_mvdone: assert property (p_mvdone) else $error("move outside write-back");
  property p_mvaddr;
    move_wr_r.valid |-> move_wr_r.addr == $past(addr_b_r, 2);
  endproperty
  a_mvaddr: assert property (p_mvaddr) else $error("move address");
  property p_mvdata;
    move_wr_r.valid |-> move_wr_r.data == $past(operand_bus_b, 3);
  endproperty
  a_mvdata: assert property (p_mvdata) else $error("move data");
  property p_frac;
    exec_done_r && fractional_shift_bit |-> !product_r[0];
  endproperty
  a_frac: assert property (p_frac) else $error("product not scaled");
  property p_err;
    idx_range_err_r |-> addr_valid_r && (addr_b_r < DPRAM_BASE || addr_b_r > DPRAM_LAST);
  endproperty
  a_err: assert property (p_err) else $error("range error in window");
endmodule
bind mcoag_top mcoag_top_monitor i_mcoag_top_monitor (.core_clk, .rst, .fetch_word_valid,
  .operand_bus_b, .fractional_shift_bit, .addr_valid_r, .addr_b_r, .idx_range_err_r,
  .gpr_wr_en_r, .move_wr_r, .product_r, .exec_done_r);
`default_nettype wire

// File: mcoag_host.sv
// Purpose: cpu core register file seen by the coprocessor
// Assumes: pointer write-backs come one per instruction
// Notes:   read is combinational so decode never waits
`timescale 1ns/100ps
`default_nettype none
module mcoag_host
  import mcoag_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  gpr_rd_sel_r,
  input  wire logic        gpr_wr_en_r,
  input  wire logic [3:0]  gpr_wr_sel_r,
  input  wire logic [15:0] gpr_wr_val_r,
  output logic      [15:0] gpr_value
);
  logic [15:0] gpr_file [16];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int n = 0; n < 16; n++) begin
        gpr_file[n] <= 16'h2000 + 16'(n * 16'h0112);
      end
    end else if (gpr_wr_en_r) begin
      gpr_file[gpr_wr_sel_r] <= gpr_wr_val_r;
    end
  end
  assign gpr_value = gpr_file[gpr_rd_sel_r];
endmodule
`default_nettype wire

// File: mcoag_top_tb.sv
// Purpose: self-checking bench for mcoag_top
// Assumes: one instruction issued once the previous one shows its addresses
// Notes:   expectations queued at issue, compared as results appear
`timescale 1ns/100ps
`default_nettype none
module mcoag_top_tb;
  import mcoag_pkg::*;
  typedef struct packed {
    logic [15:0] aa, ab, ma, md;
    logic        err, chkp, mv;
    logic [39:0] pr;
  } mcoag_exp_t;
  logic         core_clk, rst, fetch_word_valid, fractional_shift_bit, ptr_load;
  logic [15:0]  fetch_word, gpr_value, operand_bus_a, operand_bus_b, addr_a_r, addr_b_r;
  logic         instr_ready_r, addr_valid_r, idx_range_err_r, gpr_wr_en_r, exec_done_r;
  logic         store_ok_r;
  logic [3:0]   gpr_rd_sel_r, gpr_wr_sel_r;
  logic [15:0]  gpr_wr_val_r, ob, gm [16];
  logic [39:0]  product_r;
  logic [31:0]  seed = 32'hbc9a, r;
  logic [19:0]  qg [$], eg;
  mcoag_instr_t instr_in, ins;
  mcoag_ptrs_t  ptr_load_val, ptrs_r, ps;
  mcoag_wr_t    move_wr_r;
  mcoag_exp_t   qa [$], qd [$], ea, ed;
  int           fails = 0, compares = 0;
  mcoag_top i_mcoag_top (.*);
  mcoag_host i_mcoag_host (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wt(bit w);
    for (int k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if ((w ? addr_valid_r : instr_ready_r) === 1'b1) return;
    end
    chk("wait", 0, 1);
    finish_test();
  endtask
  // post-modify, or its inverse for the move address
  function automatic logic [15:0] pm(logic [15:0] p, mcoag_pmod_t m, logic [15:0] q, bit iv);
    logic [15:0] d;
    d = (m == MCOAG_PM_INC || m == MCOAG_PM_DEC) ? PTR_STEP : q;
    if (m == MCOAG_PM_NONE) return p;
    return ((m == MCOAG_PM_DEC || m == MCOAG_PM_SUBQ) ^ iv) ? p - d : p + d;
  endfunction
  function automatic logic [39:0] prod(logic [15:0] a, b, logic sa, sb);
    logic [39:0] x, y;
    x = sa ? {{24{a[15]}}, a} : {24'h0, a};
    y = sb ? {{24{b[15]}}, b} : {24'h0, b};
    x = x * y;
    return fractional_shift_bit ? x << 1 : x;
  endfunction
  task automatic load(mcoag_ptrs_t v);
    ptr_load <= 1'b1;
    ptr_load_val <= v;
    @(posedge core_clk);
    ptr_load <= 1'b0;
    ps = v;
    @(posedge core_clk);
    chk("ptrs", ptrs_r, v);
  endtask
  task automatic issue(mcoag_instr_t i, logic [15:0] a, logic [15:0] b);
    mcoag_exp_t e;
    logic [15:0] p, q, np;
    p = i.idx_sel ? ps.index_pointer_b : ps.index_pointer_a;
    q = i.idx_q_sel ? ps.index_offset_b : ps.index_offset_a;
    np = pm(p, i.idx_mod, q, 0);
    if (i.idx_sel) ps.index_pointer_b = np;
    else ps.index_pointer_a = np;
    e.aa = gm[i.gpr_sel];
    e.ab = p;
    e.err = i.op != MCOAG_OP_MOV && (p < DPRAM_BASE || p > DPRAM_LAST);
    e.chkp = i.op != MCOAG_OP_MOV;
    e.pr = prod(a, b, i.a_signed, i.b_signed);
    e.mv = i.op == MCOAG_OP_MACM;
    e.ma = pm(np, i.idx_mod, q, 1);
    e.md = b;
    gm[i.gpr_sel] = pm(gm[i.gpr_sel], i.gpr_mod, i.gpr_q_sel ? ps.gpr_offset_b : ps.gpr_offset_a, 0);
    if (i.gpr_mod != MCOAG_PM_NONE) qg.push_back({i.gpr_sel, gm[i.gpr_sel]});
    qa.push_back(e);
    qd.push_back(e);
    fetch_word_valid <= 1'b1;
    fetch_word <= 16'(rnd());
    wt(0);
    fetch_word <= 16'(rnd());
    instr_in <= i;
    operand_bus_a <= a;
    operand_bus_b <= b;
    @(posedge core_clk);
    fetch_word_valid <= 1'b0;
    wt(1);
  endtask
  always @(posedge core_clk) begin
    if (!rst && addr_valid_r === 1'b1) begin
      ea = qa.size() ? qa.pop_front() : '1;
      chk("addr_a", addr_a_r, ea.aa);
      chk("addr_b", addr_b_r, ea.ab);
      chk("range_err", idx_range_err_r, ea.err);
    end
    if (!rst && gpr_wr_en_r === 1'b1) begin
      eg = qg.size() ? qg.pop_front() : '1;
      chk("gpr_wr", {gpr_wr_sel_r, gpr_wr_val_r}, eg);
    end
    if (!rst && exec_done_r === 1'b1) begin
      ed = qd.size() ? qd.pop_front() : '1;
      if (ed.chkp) chk("product", product_r, ed.pr);
      chk("move_valid", move_wr_r.valid, ed.mv);
      if (ed.mv) chk("move", {move_wr_r.addr, move_wr_r.data}, {ed.ma, ed.md});
      // a store right after the operation must not be held off
      chk("store_ok", store_ok_r, 1);
    end
  end
  initial begin
    {rst, fetch_word_valid, fractional_shift_bit, ptr_load} = 4'b1000;
    {fetch_word, operand_bus_a, operand_bus_b} = '0;
    instr_in = '0;
    ptr_load_val = '0;
    for (int n = 0; n < 16; n++) gm[n] = 16'h2000 + 16'(n * 16'h0112);
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("ptrs_reset", ptrs_r, 0);
    chk("ready_reset", instr_ready_r, 0);
    load({16'hfa40, 16'hfc00, 16'h0006, 16'h0010, 16'h0004, 16'h0020});
    for (int f = 0; f < 2; f++) begin
      fractional_shift_bit <= f[0];
      @(posedge core_clk);
      // all five modes and all sixteen pointers appear in each batch
      for (int i = 0; i < 24; i++) begin
        r = rnd();
        ins = '0;
        ins.op = mcoag_op_t'(i == 0 ? 2'd0 : r[1:0] % 3);
        ins.dbl_indirect = 1'b1;
        ins.gpr_sel = 4'(i);
        ins.gpr_mod = mcoag_pmod_t'(r[4:2] % 5);
        {ins.gpr_q_sel, ins.idx_sel, ins.idx_q_sel, ins.a_signed, ins.b_signed} = r[9:5];
        ins.idx_mod = mcoag_pmod_t'(r[12:10] % 5);
        ob = r[31:16];
        // unsigned by unsigned kept below 2^31 so the sign extension is unambiguous
        if (!r[6] && !r[5]) ob[15] = 1'b0;
        issue(ins, 16'(rnd()), ob);
      end
      repeat (6) @(posedge core_clk);
      $display("test batch %0d done", f);
    end
    load({16'hfdfe, 16'hfc00, 16'h0006, 16'h0010, 16'h0004, 16'h0020});
    for (int i = 0; i < 4; i++) begin
      ins = '0;
      ins.op = i == 2 ? MCOAG_OP_MOV : (i == 3 ? MCOAG_OP_MACM : MCOAG_OP_MAC);
      ins.dbl_indirect = 1'b1;
      ins.gpr_sel = 4'(i);
      ins.idx_mod = MCOAG_PM_INC;
      {ins.a_signed, ins.b_signed} = 2'b11;
      issue(ins, 16'h8000, 16'h8000);
    end
    repeat (8) @(posedge core_clk);
    $display("test window edge done");
    chk("ptrs_end", ptrs_r, ps);
    chk("queues", 96'(qa.size() + qd.size() + qg.size()), 0);
    finish_test();
  end
endmodule
`default_nettype wire
